// File: pmbus_fault_status_registers.v
// Output voltage and current fault flags with summary status word
`timescale 1ns/1ps
`include "fault_status_defines.vh"

module pmbus_fault_status_registers (
  input  wire        core_clk_i,       // Core clock, 250 MHz
  input  wire        rst_i,            // Power-up reset, async, high
  input  wire        cmd_valid_i,      // Command strobe, one cycle
  input  wire        cmd_write_i,      // 1 write, 0 read
  input  wire [7:0]  cmd_code_i,       // Command code
  input  wire [15:0] cmd_wdata_i,      // Write data, byte in [7:0]
  input  wire        clear_faults_i,   // Clear-all command pulse
  input  wire        output_on_i,      // Output turned on pulse
  input  wire        ov_fault_det_i,   // Overvoltage fault detect (async)
  input  wire        ov_warn_det_i,    // Overvoltage warning detect (async)
  input  wire        uv_warn_det_i,    // Undervoltage warning detect (async)
  input  wire        uv_fault_det_i,   // Undervoltage fault detect (async)
  input  wire        clamp_det_i,      // Setpoint clamp warning (async)
  input  wire        oc_fault_det_i,   // Overcurrent fault detect (async)
  input  wire        oclv_det_i,       // Overcurrent at low voltage (async)
  input  wire        oc_warn_det_i,    // Overcurrent warning detect (async)
  input  wire        uc_fault_det_i,   // Undercurrent fault detect (async)
  input  wire        soft_start_done_i,// Soft start complete (async)
  input  wire        pnotgood_det_i,   // Output outside window (async)
  input  wire        secondary_i,      // Stack secondary strap (async)
  input  wire        not_converting_i, // Device not converting power
  input  wire [4:0]  vout_disable_i,   // Disable bits for voltage [7:3]
  input  wire [3:0]  iout_disable_i,   // Disable bits for current [7:4]
  input  wire [7:0]  input_flags_i,    // Input status byte
  input  wire [7:0]  vendor_flags_i,   // Vendor status byte
  input  wire [7:0]  other_flags_i,    // Other status byte
  input  wire        temp_any_i,       // Any temperature flag set
  input  wire        cml_any_i,        // Any communication flag set
  input  wire        mask_wr_i,        // Overcurrent mask write pulse
  input  wire [1:0]  mask_wdata_i,     // [1] fault mask, [0] warning mask
  input  wire        nvm_store_i,      // Store warning mask to NVM pulse
  input  wire        nvm_restore_i,    // Restore masks from NVM pulse
  output reg  [15:0] rd_data_o,        // Read data
  output reg         rd_valid_o,       // Read data valid pulse
  output reg         invalid_data_o,   // Invalid data pulse
  output reg         oc_alert_o,       // Unmasked overcurrent alert level
  output reg  [1:0]  oc_mask_o,        // Current masks [1] fault [0] warning
  output reg         power_good_pin_o, // Power-good pin output level
  output reg         power_good_pin_oe_o // Power-good pin enable
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  localparam NSYNC = 12;

  reg  [NSYNC-1:0] sync1_q;
  reg  [NSYNC-1:0] sync2_q;
  wire [NSYNC-1:0] async_in;

  assign async_in = {secondary_i, pnotgood_det_i, soft_start_done_i,
                     uc_fault_det_i, oc_warn_det_i, oclv_det_i,
                     oc_fault_det_i, clamp_det_i, uv_fault_det_i,
                     uv_warn_det_i, ov_warn_det_i, ov_fault_det_i};

  // Two flip-flops for each pin input
  always @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1_q <= {NSYNC{1'b0}};
      sync2_q <= {NSYNC{1'b0}};
    end
    else
    begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end

  wire ov_fault_s = sync2_q[0];
  wire ov_warn_s  = sync2_q[1];
  wire uv_warn_s  = sync2_q[2];
  wire uv_fault_s = sync2_q[3];
  wire clamp_s    = sync2_q[4];
  wire oc_fault_s = sync2_q[5];
  wire oclv_s     = sync2_q[6];
  wire oc_warn_s  = sync2_q[7];
  wire uc_fault_s = sync2_q[8];
  wire ss_s       = sync2_q[9];
  wire png_s      = sync2_q[10];
  wire second_s   = sync2_q[11];

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  wire wr_cmd   = cmd_valid_i & cmd_write_i;
  wire rd_cmd   = cmd_valid_i & ~cmd_write_i;
  wire wr_vout  = wr_cmd & (cmd_code_i == `CMD_VOUT_FLAGS);
  wire wr_iout  = wr_cmd & (cmd_code_i == `CMD_IOUT_FLAGS);
  wire clr_all  = clear_faults_i | output_on_i;

  // Write-one-to-clear masks, zero when not written
  wire [7:0] w1c_vout = wr_vout ? cmd_wdata_i[7:0] : 8'h00;
  wire [7:0] w1c_iout = wr_iout ? cmd_wdata_i[7:0] : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Latched flag sets

  reg [7:0] vout_set;
  reg [7:0] iout_set;

  // Build set vectors from the detectors
  always @*
  begin
    vout_set = 8'h00;
    iout_set = 8'h00;
    vout_set[`VO_OV_FAULT_BIT] = ov_fault_s;
    // fixed fault before soft start sets no warning
    vout_set[`VO_OV_WARN_BIT]  = ov_warn_s | (ov_fault_s & ss_s);
    vout_set[`VO_UV_WARN_BIT]  = uv_warn_s | uv_fault_s;
    vout_set[`VO_UV_FAULT_BIT] = uv_fault_s;
    vout_set[`VO_CLAMP_BIT]    = clamp_s;
    iout_set[`IO_OC_FAULT_BIT] = oc_fault_s;
    iout_set[`IO_OCLV_BIT]     = oclv_s;
    iout_set[`IO_OC_WARN_BIT]  = oc_warn_s;
    iout_set[`IO_UC_FAULT_BIT] = uc_fault_s;
    vout_set[7:3] = vout_set[7:3] & ~vout_disable_i;
    iout_set[7:4] = iout_set[7:4] & ~iout_disable_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag registers

  reg  [7:0] vout_q;
  reg  [7:0] iout_q;
  reg  [7:0] vout_d;
  reg  [7:0] iout_d;
  reg  [7:0] iout_clr;

  // Next flag values; set wins over every clear
  always @*
  begin
    iout_clr = w1c_iout;
    // writes ignored, cleared through voltage bit 4
    iout_clr[`IO_OCLV_BIT] = w1c_vout[`VO_UV_FAULT_BIT];
    vout_d = clr_all ? 8'h00 : (vout_q & ~w1c_vout);
    iout_d = clr_all ? 8'h00 : (iout_q & ~iout_clr);
    vout_d = vout_d | vout_set;
    iout_d = iout_d | iout_set;
    vout_d[2:0] = 3'b000;
    iout_d[3:0] = 4'b0000;
  end

  // Flags cleared by power-up reset, clear-all pulses and write-one-to-clear
  always @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      vout_q <= `VOUT_FLAGS_RESET;
      iout_q <= `IOUT_FLAGS_RESET;
    end
    else
    begin
      vout_q <= vout_d;
      iout_q <= iout_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Summary byte and word

  wire [7:0]  status_byte;
  wire [15:0] status_word;
  wire png_rep  = png_s & ~second_s;
  wire vend_any = |(vendor_flags_i & ~(8'h01 << `VENDOR_CONDUCTION_BIT));
  wire oth_any  = vout_q[`VO_CLAMP_BIT] | vout_q[`VO_UV_FAULT_BIT] |
                  vout_q[`VO_OV_WARN_BIT] | vout_q[`VO_UV_WARN_BIT] |
                  iout_q[`IO_OC_WARN_BIT] | (|input_flags_i) |
                  other_flags_i[`FIRST_ALERT_BIT];

  // low byte is the one-byte summary
  assign status_byte = second_s ? 8'h00 :
         {1'b0, not_converting_i, vout_q[`VO_OV_FAULT_BIT],
          iout_q[`IO_OC_FAULT_BIT] | iout_q[`IO_OCLV_BIT], 1'b0,
          temp_any_i, cml_any_i, oth_any};

  assign status_word = {|vout_q,
                        iout_q[`IO_OC_FAULT_BIT] | iout_q[`IO_OC_WARN_BIT],
                        |input_flags_i,
                        vend_any,
                        png_rep,
                        1'b0,
                        other_flags_i[`FIRST_ALERT_BIT],
                        1'b0,
                        status_byte};

  ////////////////////////////////////////////////////////////////////////////
  // Read path and refused writes

  // Registered read answer one cycle after the strobe
  always @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_data_o      <= 16'h0000;
      rd_valid_o     <= 1'b0;
      invalid_data_o <= 1'b0;
    end
    else
    begin
      rd_valid_o <= 1'b0;
      invalid_data_o <= wr_cmd & ((cmd_code_i == `CMD_SUMMARY_WORD) |
                                  (cmd_code_i == `CMD_ONE_BYTE_SUMMARY));
      if (rd_cmd)
      begin
        case (cmd_code_i)
          `CMD_SUMMARY_WORD:
          begin
            rd_data_o  <= status_word;
            rd_valid_o <= 1'b1;
          end
          `CMD_ONE_BYTE_SUMMARY:
          begin
            rd_data_o  <= {8'h00, status_byte};
            rd_valid_o <= 1'b1;
          end
          `CMD_VOUT_FLAGS:
          begin
            rd_data_o  <= {8'h00, vout_q};
            rd_valid_o <= 1'b1;
          end
          `CMD_IOUT_FLAGS:
          begin
            rd_data_o  <= {8'h00, iout_q};
            rd_valid_o <= 1'b1;
          end
          default:
          begin
            rd_data_o <= rd_data_o;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overcurrent alert masks and stored default

  reg nvm_mask_q;

  always @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      nvm_mask_q <= `OC_MASK_NVM_RESET;
      oc_mask_o  <= {2{`OC_MASK_NVM_RESET}};
    end
    else
    begin
      if (nvm_store_i)
        nvm_mask_q <= oc_mask_o[0];
      if (nvm_restore_i)
        oc_mask_o <= {nvm_mask_q, nvm_mask_q};
      else if (mask_wr_i)
        oc_mask_o <= mask_wdata_i;
    end
  end

  always @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      oc_alert_o <= 1'b0;
    else
      oc_alert_o <= (iout_q[`IO_OC_FAULT_BIT] & ~oc_mask_o[1]) |
                    (iout_q[`IO_OC_WARN_BIT] & ~oc_mask_o[0]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-good pin, open drain

  // pin pulled low while not good and not a stack secondary
  always @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      power_good_pin_o    <= 1'b0;
      power_good_pin_oe_o <= 1'b0;
    end
    else
    begin
      power_good_pin_o    <= 1'b0;
      power_good_pin_oe_o <= png_rep;
    end
  end

endmodule // pmbus_fault_status_registers

// File: fault_status_defines.vh
// Command codes, bit positions and reset values of the fault status bank
`ifndef FAULT_STATUS_DEFINES_VH
`define FAULT_STATUS_DEFINES_VH

// Command codes
`define CMD_ONE_BYTE_SUMMARY   8'h78
`define CMD_SUMMARY_WORD       8'h79
`define CMD_VOUT_FLAGS         8'h7A
`define CMD_IOUT_FLAGS         8'h7B

// Summary word upper-byte positions
`define SW_VOLTAGE_BIT         15
`define SW_CURRENT_BIT         14
`define SW_INPUT_BIT           13
`define SW_VENDOR_BIT          12
`define SW_PNOTGOOD_BIT        11
`define SW_OTHER_BIT           9

// One-byte summary positions
`define SB_OFF_BIT             6
`define SB_OV_FAULT_BIT        5
`define SB_OC_FAULT_BIT        4
`define SB_TEMP_BIT            2
`define SB_CML_BIT             1
`define SB_OTH_BIT             0

// Output-voltage flag positions
`define VO_OV_FAULT_BIT        7
`define VO_OV_WARN_BIT         6
`define VO_UV_WARN_BIT         5
`define VO_UV_FAULT_BIT        4
`define VO_CLAMP_BIT           3

// Output-current flag positions
`define IO_OC_FAULT_BIT        7
`define IO_OCLV_BIT            6
`define IO_OC_WARN_BIT         5
`define IO_UC_FAULT_BIT        4

// Vendor byte bit excluded from the summary; other byte first-alert bit
`define VENDOR_CONDUCTION_BIT  7
`define FIRST_ALERT_BIT        0

// Reset values
`define VOUT_FLAGS_RESET       8'h00
`define IOUT_FLAGS_RESET       8'h00
`define OC_MASK_NVM_RESET      1'b0

`endif

// File: fault_status_asserts.sv
// Port checker for the fault status bank
`timescale 1ns/1ps
module fault_status_asserts (
  input wire        core_clk_i,         // Core clock
  input wire        rst_i,              // Async reset
  input wire        cmd_valid_i,        // Command strobe
  input wire        cmd_write_i,        // Write select
  input wire [7:0]  cmd_code_i,         // Command code
  input wire        secondary_i,        // Secondary strap
  input wire        pnotgood_det_i,     // Output outside window
  input wire        mask_wr_i,          // Mask write
  input wire [1:0]  mask_wdata_i,       // Mask data
  input wire        nvm_restore_i,      // Mask restore
  input wire [15:0] rd_data_o,          // Read data
  input wire        rd_valid_o,         // Read valid
  input wire        invalid_data_o,     // Refusal pulse
  input wire [1:0]  oc_mask_o,          // Current masks
  input wire        power_good_pin_o,   // Pin level
  input wire        power_good_pin_oe_o // Pin enable
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////
  // Command answers
  rd_answer_a:
    assert property (cmd_valid_i && !cmd_write_i
      && cmd_code_i[7:2] == 6'h1E |=> rd_valid_o) else $error("no answer");
  rd_source_a:
    assert property (rd_valid_o |-> $past(cmd_valid_i && !cmd_write_i))
      else $error("answer without read");
  word_refused_a:
    assert property (cmd_valid_i && cmd_write_i && cmd_code_i == 8'h79
      |=> invalid_data_o) else $error("word write not refused");
  byte_refused_a:
    assert property (cmd_valid_i && cmd_write_i && cmd_code_i == 8'h78
      |=> invalid_data_o) else $error("byte write not refused");

  ////////////////////////////////////////////////////////////////////////
  // Unsupported positions
  vout_zero_a:
    assert property (rd_valid_o && $past(cmd_code_i) == 8'h7A
      |-> rd_data_o[2:0] == 3'h0 && rd_data_o[15:8] == 8'h0)
      else $error("voltage byte spare bits set");
  iout_zero_a:
    assert property (rd_valid_o && $past(cmd_code_i) == 8'h7B
      |-> rd_data_o[3:0] == 4'h0 && rd_data_o[15:8] == 8'h0)
      else $error("current byte spare bits set");
  word_zero_a:
    assert property (rd_valid_o && $past(cmd_code_i) == 8'h79
      |-> !rd_data_o[10] && !rd_data_o[8]) else $error("word spare bits set");

  ////////////////////////////////////////////////////////////////////////
  // Power-good and stacking
  second_word_a:
    assert property (secondary_i[*6] ##0 (rd_valid_o
      && $past(cmd_code_i) == 8'h79) |-> !rd_data_o[11])
      else $error("secondary shows not good");
  second_pin_a:
    assert property (secondary_i[*6] |-> !power_good_pin_oe_o)
      else $error("secondary drives pin");
  pin_low_a:
    assert property (power_good_pin_oe_o |-> !power_good_pin_o)
      else $error("pin driven high");
  pin_drive_a:
    assert property ((pnotgood_det_i && !secondary_i)[*4]
      |=> power_good_pin_oe_o) else $error("pin not pulled low");

  ////////////////////////////////////////////////////////////////////////
  // Overcurrent masks
  mask_write_a:
    assert property (mask_wr_i && !nvm_restore_i
      |=> oc_mask_o == $past(mask_wdata_i)) else $error("mask not written");
  mask_reset_a:
    assert property ($past(rst_i) |-> oc_mask_o == 2'h0)
      else $error("masks set after reset");
endmodule // fault_status_asserts

bind pmbus_fault_status_registers fault_status_asserts fault_status_asserts_inst
(
  .core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
  .cmd_write_i(cmd_write_i), .cmd_code_i(cmd_code_i),
  .secondary_i(secondary_i), .pnotgood_det_i(pnotgood_det_i),
  .mask_wr_i(mask_wr_i),
  .mask_wdata_i(mask_wdata_i), .nvm_restore_i(nvm_restore_i),
  .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
  .invalid_data_o(invalid_data_o), .oc_mask_o(oc_mask_o),
  .power_good_pin_o(power_good_pin_o),
  .power_good_pin_oe_o(power_good_pin_oe_o)
);

// File: host_model.sv
// Host controller model on the command port
`timescale 1ns/1ps
module host_model (
  input  wire        clk_i,          // Core clock
  output reg         cmd_valid_o,    // Command strobe
  output reg         cmd_write_o,    // Write select
  output reg  [7:0]  cmd_code_o,     // Command code
  output reg  [15:0] cmd_wdata_o,    // Write data
  output reg         clear_faults_o, // Clear-all pulse
  output reg         output_on_o     // Output turn-on pulse
);
  // Idle bus at time zero
  initial
  begin
    {cmd_valid_o, cmd_write_o, cmd_code_o, cmd_wdata_o,
      clear_faults_o, output_on_o} = 28'h0;
  end

  task xfer(input w, input [7:0] c, input [15:0] d);
  begin
    @(posedge clk_i);
    #1 {cmd_valid_o, cmd_write_o, cmd_code_o, cmd_wdata_o} = {1'b1, w, c, d};
    @(posedge clk_i);
    // Released lines carry a changed pattern
    #1 {cmd_valid_o, cmd_write_o, cmd_code_o, cmd_wdata_o} = {1'b0, ~w, ~c, ~d};
  end
  endtask

  task pulse(input sel);
  begin
    @(posedge clk_i);
    #1 {output_on_o, clear_faults_o} = {sel, ~sel};
    @(posedge clk_i);
    #1 {output_on_o, clear_faults_o} = 2'h0;
  end
  endtask
endmodule // host_model

// File: pmbus_fault_status_registers_test.sv
// Self-checking bench for the fault status bank
`timescale 1ns/1ps
module pmbus_fault_status_registers_test;
  reg          clk = 1'b0;
  reg          rst = 1'b1;
  reg  [8:0]   det = 9'h0;   // Detectors, overvoltage fault at top
  reg          ss = 1'b0, png = 1'b0, sec = 1'b0, noc = 1'b0;
  reg  [4:0]   vdis = 5'h0;
  reg  [3:0]   idis = 4'h0;
  reg  [7:0]   inf = 8'h0, vnd = 8'h0, oth = 8'h0, bt;
  reg          tmp = 1'b0, cml = 1'b0, mwr = 1'b0, nst = 1'b0, nrs = 1'b0;
  reg  [1:0]   mwd = 2'h0;
  reg  [31:0]  seed = 32'h83A4462D;
  wire         cv, cw, cf, on, rv, idv, al, pgo, pge;
  wire [7:0]   cc;
  wire [15:0]  cd, rdat;
  wire [1:0]   msk;
  logic [15:0] expq[$];
  integer      fails = 0, checks = 0, i;

  always #2 clk = ~clk;

  host_model host_model_inst (.clk_i(clk), .cmd_valid_o(cv),
    .cmd_write_o(cw), .cmd_code_o(cc), .cmd_wdata_o(cd),
    .clear_faults_o(cf), .output_on_o(on));

  pmbus_fault_status_registers pmbus_fault_status_registers_inst (
    .core_clk_i(clk), .rst_i(rst), .cmd_valid_i(cv), .cmd_write_i(cw),
    .cmd_code_i(cc), .cmd_wdata_i(cd), .clear_faults_i(cf),
    .output_on_i(on), .ov_fault_det_i(det[8]), .ov_warn_det_i(det[7]),
    .uv_warn_det_i(det[6]), .uv_fault_det_i(det[5]),
    .clamp_det_i(det[4]), .oc_fault_det_i(det[3]), .oclv_det_i(det[2]),
    .oc_warn_det_i(det[1]), .uc_fault_det_i(det[0]),
    .soft_start_done_i(ss), .pnotgood_det_i(png),
    .secondary_i(sec), .not_converting_i(noc), .vout_disable_i(vdis),
    .iout_disable_i(idis), .input_flags_i(inf), .vendor_flags_i(vnd),
    .other_flags_i(oth), .temp_any_i(tmp), .cml_any_i(cml),
    .mask_wr_i(mwr), .mask_wdata_i(mwd), .nvm_store_i(nst),
    .nvm_restore_i(nrs), .rd_data_o(rdat), .rd_valid_o(rv),
    .invalid_data_o(idv), .oc_alert_o(al), .oc_mask_o(msk),
    .power_good_pin_o(pgo), .power_good_pin_oe_o(pge));

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction

  task chk(input [15:0] s, input [15:0] e);
  begin
    checks = checks + 1;
    if (s !== e)
    begin
      fails = fails + 1;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  end
  endtask

  task rd(input [7:0] c, input [15:0] e);
  begin
    expq.push_back(e);
    host_model_inst.xfer(1'b0, c, 16'h0);
  end
  endtask

  task wr(input [7:0] c, input [7:0] d);
    host_model_inst.xfer(1'b1, c, {8'h0, d});
  endtask

  task hit(input [8:0] m);
  begin
    @(posedge clk);
    #1 det = m;
    repeat (4) @(posedge clk);
    #1 det = 9'h0;
    repeat (4) @(posedge clk);
  end
  endtask

  task conclude;
  begin
    // An answer still owed counts as a mismatch
    if (expq.size() != 0)
      fails = fails + 1;
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask

  // Compare each answer with the oldest note
  always @(negedge clk)
    if (rv === 1'b1)
      chk(rdat, expq.size() ? expq.pop_front() : 16'hXXXX);

  // Cut a hang short
  initial
  begin
    #40000 fails = fails + 1;
    conclude;
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    chk({14'h0, msk}, 16'h0);
    rd(8'h79, 16'h0000);
    rd(8'h7A, 16'h0000);
    rd(8'h7B, 16'h0000);
    ss = 1'b1;
    hit(9'h100);
    rd(8'h7A, 16'h00C0);
    rd(8'h79, 16'h8021);
    wr(8'h7A, 8'h80);
    rd(8'h7A, 16'h0040);
    wr(8'h7A, 8'h40);
    rd(8'h7A, 16'h0000);
    ss = 1'b0;
    hit(9'h100);
    rd(8'h7A, 16'h0080);
    host_model_inst.pulse(1'b0);
    rd(8'h7A, 16'h0000);
    hit(9'h024);
    rd(8'h7A, 16'h0030);
    rd(8'h7B, 16'h0040);
    wr(8'h7B, 8'h40);
    rd(8'h7B, 16'h0040);
    wr(8'h7A, 8'h10);
    rd(8'h7A, 16'h0020);
    rd(8'h7B, 16'h0000);
    wr(8'h7A, 8'h20);
    hit(9'h00B);
    rd(8'h7B, 16'h00B0);
    rd(8'h79, 16'h4011);
    chk({15'h0, al}, 16'h0001);
    wr(8'h7B, 8'h20);
    rd(8'h7B, 16'h0090);
    host_model_inst.pulse(1'b1);
    rd(8'h7B, 16'h0000);
    vdis = 5'h1F;
    idis = 4'hF;
    hit(9'h1FF);
    rd(8'h7A, 16'h0000);
    rd(8'h7B, 16'h0000);
    vdis = 5'h0;
    idis = 4'h0;
    hit(9'h010);
    rd(8'h79, 16'h8001);
    wr(8'h7A, 8'h08);
    rd(8'h7A, 16'h0000);
    png = 1'b1;
    wr(8'h79, 8'h00);
    wr(8'h78, 8'h00);
    rd(8'h79, 16'h0800);
    sec = 1'b1;
    repeat (6) @(posedge clk);
    rd(8'h79, 16'h0000);
    {sec, png} = 2'h0;
    host_model_inst.xfer(1'b0, 8'h7C, 16'h0);
    // Masks: run-time write, store, change, restore
    @(posedge clk);
    #1 {mwr, mwd} = 3'h5;
    @(posedge clk);
    #1 {mwr, nst} = 2'h1;
    @(posedge clk);
    #1 {nst, mwr, mwd} = 4'h6;
    @(posedge clk);
    #1 {mwr, nrs} = 2'h1;
    @(posedge clk);
    #1 nrs = 1'b0;
    chk({14'h0, msk}, 16'h0003);
    // Masked warning still latches but raises no alert
    hit(9'h002);
    rd(8'h7B, 16'h0020);
    chk({15'h0, al}, 16'h0000);
    wr(8'h7B, 8'h20);
    // Random source bytes into the summaries
    for (i = 0; i < 6; i = i + 1)
    begin
      seed = xs(seed);
      {noc, cml, tmp, oth[0], vnd, inf} = seed[19:0];
      bt = {1'b0, noc, 3'h0, tmp, cml, |inf | oth[0]};
      rd(8'h79, {2'h0, |inf, |vnd[6:0], 2'h0, oth[0], 1'b0, bt});
      rd(8'h78, {8'h0, bt});
    end
    repeat (4) @(posedge clk);
    conclude;
  end
endmodule // pmbus_fault_status_registers_test
